//--- design/ppi_pkg.sv
// Shared constants and carrier types of the process PI controller.
// Assumes one 125 MHz clock and percent values in signed 0.1 % steps.
package ppi_pkg;
   localparam int CLK_PERIOD_NS  = 8;
   localparam int SAMPLE_TIME_US = 1000;
   localparam int SAMPLE_CYCLES  = SAMPLE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int TI_UNIT_US     = 10000;
   localparam int TI_SCALE       = 100 * TI_UNIT_US / SAMPLE_TIME_US;
   localparam int PGAIN_DIV      = 100;
   localparam int FRAC_BITS      = 16;
   localparam int DIV_W          = 48;

   // Parameter numbers: group * 100 + index
   localparam logic [9:0] IDX_PI_SETPOINT_MONITOR     = 10'h01e;
   localparam logic [9:0] IDX_PI_FEEDBACK_MONITOR     = 10'h01f;
   localparam logic [9:0] IDX_PI_ERROR_MONITOR        = 10'h020;
   localparam logic [9:0] IDX_PI_OUTPUT_MONITOR       = 10'h021;
   localparam logic [9:0] IDX_SETPOINT_SOURCE_SELECT  = 10'h104;
   localparam logic [9:0] IDX_FEEDBACK_SOURCE_SELECT  = 10'h105;
   localparam logic [9:0] IDX_ERROR_NEGATION_ENABLE   = 10'h106;
   localparam logic [9:0] IDX_PROPORTIONAL_GAIN       = 10'h107;
   localparam logic [9:0] IDX_INTEGRAL_TIME_SETTING   = 10'h108;
   localparam logic [9:0] IDX_OUTPUT_UPPER_LIMIT      = 10'h10a;
   localparam logic [9:0] IDX_OUTPUT_LOWER_LIMIT      = 10'h10b;
   localparam logic [9:0] IDX_STOP_RESET_BEHAVIOUR    = 10'h10c;

   localparam logic [11:0]        PGAIN_MIN   = 12'h001;
   localparam logic [11:0]        PGAIN_MAX   = 12'hbb8;
   localparam logic [14:0]        TI_MIN      = 15'h0001;
   localparam logic [14:0]        TI_MAX      = 15'h7d00;
   localparam logic signed [15:0] UPPER_MAX   = 16'sh7530;
   localparam logic signed [15:0] LOWER_MIN   = 16'sh8ad0;
   localparam logic signed [15:0] KEYPAD_MAX  = 16'sh03e8;
   localparam logic signed [15:0] MON_MIN     = 16'sh8000;
   localparam logic signed [15:0] MON_MAX     = 16'sh7fff;

   localparam logic [2:0] SRC_KEYPAD  = 3'h0;
   localparam logic [2:0] SRC_ANALOG1 = 3'h1;
   localparam logic [2:0] SRC_ANALOG2 = 3'h2;
   localparam logic [2:0] SRC_SERIAL  = 3'h4;
   localparam logic [2:0] REF_SRC_PI  = 3'h4;

   localparam logic [11:0]        RST_PGAIN = 12'h064;
   localparam logic [14:0]        RST_TI    = 15'h0064;
   localparam logic signed [15:0] RST_UPPER = 16'sh03e8;
   localparam logic signed [15:0] RST_LOWER = 16'sh0000;

   typedef struct packed {
      logic [2:0]        sp_src;
      logic              fb_src;
      logic              neg;
      logic [11:0]       pgain;
      logic [14:0]       ti;
      logic signed [15:0] hi;
      logic signed [15:0] lo;
      logic              keep_run;
   } ppi_cfg_t;

   typedef struct packed {
      logic signed [15:0] sp;
      logic signed [15:0] fb;
      logic signed [15:0] err;
      logic signed [15:0] out;
   } ppi_mon_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_PROP  = 4'b0010,
      ST_INTEG = 4'b0100,
      ST_APPLY = 4'b1000
   } ppi_state_t;
endpackage

//--- design/ppi_sat.sv
// Signed saturating narrow: clamps a wide value into [lo, hi].
// Assumes lo <= hi; purely combinational.
`timescale 1ns/1ps
module ppi_sat #(
   parameter int IW = 17,
   parameter int OW = 16
)(
   // Value and bounds
   input  wire logic signed [IW-1:0] val,
   input  wire logic signed [OW-1:0] lo,
   input  wire logic signed [OW-1:0] hi,
   // Result
   output logic signed [OW-1:0]      res
);
   generate
      if (IW < OW) begin : g_chk
         $error("ppi_sat: IW must not be below OW");
      end
   endgenerate

   always_comb begin
      if (val < lo) begin
         res = lo;
      end else if (val > hi) begin
         res = hi;
      end else begin
         res = val[OW-1:0];
      end
   end
endmodule

//--- design/ppi_div.sv
// Serial restoring divider, one quotient bit per clock.
// Assumes a nonzero divisor; start while busy is not checked and restarts the division.
`timescale 1ns/1ps
module ppi_div #(
   parameter int W = 48
)(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Request
   input  wire logic         start,
   input  wire logic [W-1:0] dividend,
   input  wire logic [W-1:0] divisor,
   // Answer
   output logic              done,
   output logic [W-1:0]      quot
);
   localparam int CW = $clog2(W + 1);

   generate
      if (W < 2) begin : g_chk
         $error("ppi_div: W must be at least 2");
      end
   endgenerate

   logic [W-1:0]  rem_r;
   logic [W-1:0]  den_r;
   logic [CW-1:0] cnt_r;
   logic          busy_r;
   logic [W:0]    rem_sh;
   logic [W:0]    rem_sub;

   assign rem_sh  = {rem_r, quot[W-1]};
   assign rem_sub = rem_sh - {1'b0, den_r};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rem_r  <= '0;
         den_r  <= '0;
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done   <= 1'b0;
         quot   <= '0;
      end else if (start) begin
         rem_r  <= '0;
         den_r  <= divisor;
         cnt_r  <= CW'(W);
         busy_r <= 1'b1;
         done   <= 1'b0;
         quot   <= dividend;
      end else if (busy_r) begin
         if (rem_sh >= {1'b0, den_r}) begin
            rem_r <= rem_sub[W-1:0];
            quot  <= {quot[W-2:0], 1'b1};
         end else begin
            rem_r <= rem_sh[W-1:0];
            quot  <= {quot[W-2:0], 1'b0};
         end
         cnt_r <= cnt_r - CW'(1);
         if (cnt_r == CW'(1)) begin
            busy_r <= 1'b0;
            done   <= 1'b1;
         end
      end else begin
         done <= 1'b0;
      end
   end
endmodule

//--- design/ppi_ctrl.sv
// Process PI controller: parameter store, source muxing, PI loop.
// Assumes all inputs come from logic on clk; one parameter access a cycle.
`timescale 1ns/1ps
module ppi_ctrl
   import ppi_pkg::*;
#(
   parameter int SAMPLE_CYC = SAMPLE_CYCLES
)(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Parameter access
   input  wire logic               par_wr,
   input  wire logic               par_rd,
   input  wire logic [9:0]         par_idx,
   input  wire logic [15:0]        par_wdata,
   output logic [15:0]             par_rdata,
   // Reference sources
   input  wire logic signed [15:0] first_analog_reference,
   input  wire logic signed [15:0] second_analog_reference,
   input  wire logic signed [15:0] serial_link_setpoint,
   input  wire logic               keypad_up,
   input  wire logic               keypad_down,
   // Drive state
   input  wire logic               drive_run,
   input  wire logic               place_b,
   input  wire logic [2:0]         ref_src_a,
   input  wire logic [2:0]         ref_src_b,
   // Results
   output logic signed [15:0]      controller_output_reference,
   output logic                    pi_ref_active,
   output ppi_mon_t                monitor
);
   localparam int TW = $clog2(SAMPLE_CYC);

   // Two divisions must finish inside one sample period
   generate
      if (SAMPLE_CYC < 2 * DIV_W + 8) begin : g_chk
         $error("ppi_ctrl: SAMPLE_CYC too small for the divider");
      end
   endgenerate
   ppi_cfg_t           cfg_r;
   logic signed [15:0] keypad_setpoint_r;
   logic [TW-1:0]      tick_cnt_r;
   ppi_state_t         state_r;
   logic               err_neg_r;
   logic [28:0]        prod_r;
   logic [23:0]        p_r;
   logic signed [47:0] acc_r;
   logic signed [15:0] out_r;
   logic [2:0]         act_src;
   logic               pi_sel;
   logic               keypad_ok;
   logic               tick;
   logic               stop_clr;
   logic signed [15:0] sp;
   logic signed [15:0] fb;
   logic signed [16:0] err_raw;
   logic signed [16:0] err_use;
   logic [16:0]        err_mag;
   logic signed [15:0] err_mon;
   logic [28:0]        prod_now;
   logic               div_start;
   logic [DIV_W-1:0]   div_num;
   logic [DIV_W-1:0]   div_den;
   logic               div_done;
   logic [DIV_W-1:0]   div_q;
   logic signed [48:0] inc;
   logic               hold;
   logic signed [48:0] acc_sum;
   logic signed [47:0] acc_lo;
   logic signed [47:0] acc_hi;
   logic signed [47:0] acc_new;
   logic signed [24:0] p_s;
   logic signed [39:0] out_sum;
   logic signed [15:0] out_new;
   // Active control place picks its reference selector
   assign act_src   = place_b ? ref_src_b : ref_src_a;
   assign pi_sel    = (act_src == REF_SRC_PI);
   assign keypad_ok = (cfg_r.sp_src == SRC_KEYPAD) && pi_sel;
   assign stop_clr  = !drive_run && !cfg_r.keep_run;
   assign tick      = (tick_cnt_r == TW'(SAMPLE_CYC - 1));

   always_comb begin
      case (cfg_r.sp_src)
         SRC_KEYPAD:  sp = keypad_setpoint_r;
         SRC_ANALOG1: sp = first_analog_reference;
         SRC_ANALOG2: sp = second_analog_reference;
         SRC_SERIAL:  sp = serial_link_setpoint;
         default:     sp = 16'sh0000;
      endcase
   end
   assign fb = cfg_r.fb_src ? second_analog_reference : first_analog_reference;
   always_comb begin
      err_raw = {sp[15], sp} - {fb[15], fb};
      err_use = cfg_r.neg ? -err_raw : err_raw;
      err_mag = err_use[16] ? 17'(-err_use) : 17'(err_use);
      prod_now = cfg_r.pgain * err_mag;
   end
   ppi_sat #(.IW(17), .OW(16)) u_err_sat (
      .val (err_raw),
      .lo  (MON_MIN),
      .hi  (MON_MAX),
      .res (err_mon)
   );

   // Parameter writes; out-of-range values are clamped or dropped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_r.sp_src   <= SRC_KEYPAD;
         cfg_r.fb_src   <= 1'b0;
         cfg_r.neg      <= 1'b0;
         cfg_r.pgain    <= RST_PGAIN;
         cfg_r.ti       <= RST_TI;
         cfg_r.hi       <= RST_UPPER;
         cfg_r.lo       <= RST_LOWER;
         cfg_r.keep_run <= 1'b0;
      end else if (par_wr) begin
         if (par_idx == IDX_SETPOINT_SOURCE_SELECT) begin
            if (par_wdata <= 16'h0004) begin
               cfg_r.sp_src <= par_wdata[2:0];
            end
         end else if (par_idx == IDX_FEEDBACK_SOURCE_SELECT) begin
            if (par_wdata <= 16'h0001) begin
               cfg_r.fb_src <= par_wdata[0];
            end
         end else if (par_idx == IDX_ERROR_NEGATION_ENABLE) begin
            if (par_wdata <= 16'h0001) begin
               cfg_r.neg <= par_wdata[0];
            end
         end else if (par_idx == IDX_PROPORTIONAL_GAIN) begin
            if (par_wdata < 16'(PGAIN_MIN)) begin
               cfg_r.pgain <= PGAIN_MIN;
            end else if (par_wdata > 16'(PGAIN_MAX)) begin
               cfg_r.pgain <= PGAIN_MAX;
            end else begin
               cfg_r.pgain <= par_wdata[11:0];
            end
         end else if (par_idx == IDX_INTEGRAL_TIME_SETTING) begin
            if (par_wdata < 16'(TI_MIN)) begin
               cfg_r.ti <= TI_MIN;
            end else if (par_wdata > 16'(TI_MAX)) begin
               cfg_r.ti <= TI_MAX;
            end else begin
               cfg_r.ti <= par_wdata[14:0];
            end
         end else if (par_idx == IDX_OUTPUT_UPPER_LIMIT) begin
            if ($signed(par_wdata) < 16'sh0000) begin
               cfg_r.hi <= 16'sh0000;
            end else if ($signed(par_wdata) > UPPER_MAX) begin
               cfg_r.hi <= UPPER_MAX;
            end else begin
               cfg_r.hi <= $signed(par_wdata);
            end
         end else if (par_idx == IDX_OUTPUT_LOWER_LIMIT) begin
            if ($signed(par_wdata) > 16'sh0000) begin
               cfg_r.lo <= 16'sh0000;
            end else if ($signed(par_wdata) < LOWER_MIN) begin
               cfg_r.lo <= LOWER_MIN;
            end else begin
               cfg_r.lo <= $signed(par_wdata);
            end
         end else if (par_idx == IDX_STOP_RESET_BEHAVIOUR) begin
            if (par_wdata <= 16'h0001) begin
               cfg_r.keep_run <= par_wdata[0];
            end
         end
      end
   end

   // Keypad setpoint: one 0.1 % step per clock a key is held; both keys cancel
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         keypad_setpoint_r <= 16'sh0000;
      end else if (keypad_ok) begin
         if (keypad_up && !keypad_down && keypad_setpoint_r < KEYPAD_MAX) begin
            keypad_setpoint_r <= keypad_setpoint_r + 16'sh0001;
         end else if (keypad_down && !keypad_up && keypad_setpoint_r > 16'sh0000) begin
            keypad_setpoint_r <= keypad_setpoint_r - 16'sh0001;
         end
      end
   end

   // Sample period
   always_ff @(posedge clk) begin
      if (!rst_n || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + TW'(1);
      end
   end

   // One shared divider: first P = gain*e/100, then I step
   assign div_start = (state_r == ST_IDLE && tick) || (state_r == ST_PROP && div_done);
   assign div_num   = (state_r == ST_IDLE) ? {19'h0, prod_now} : {3'h0, prod_r, 16'h0};
   assign div_den   = (state_r == ST_IDLE) ? DIV_W'(PGAIN_DIV)
                                           : DIV_W'(cfg_r.ti) * DIV_W'(TI_SCALE);
   ppi_div #(.W(DIV_W)) u_div (
      .clk      (clk),
      .rst_n    (rst_n),
      .start    (div_start),
      .dividend (div_num),
      .divisor  (div_den),
      .done     (div_done),
      .quot     (div_q)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r   <= ST_IDLE;
         err_neg_r <= 1'b0;
         prod_r    <= '0;
         p_r       <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (tick) begin
                  err_neg_r <= err_use[16];
                  prod_r    <= prod_now;
                  state_r   <= ST_PROP;
               end
            end
            ST_PROP: begin
               if (div_done) begin
                  p_r     <= div_q[23:0];
                  state_r <= ST_INTEG;
               end
            end
            ST_INTEG: begin
               if (div_done) begin
                  state_r <= ST_APPLY;
               end
            end
            ST_APPLY: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end
   // Integrator step with anti-windup; fraction kept in the low bits
   always_comb begin
      inc = err_neg_r ? -$signed({1'b0, div_q}) : $signed({1'b0, div_q});
      hold = (out_r >= cfg_r.hi && !err_neg_r) || (out_r <= cfg_r.lo && err_neg_r);
      acc_sum = {acc_r[47], acc_r} + (hold ? 49'sh0 : inc);
      acc_lo = {{(32 - FRAC_BITS){cfg_r.lo[15]}}, cfg_r.lo, {FRAC_BITS{1'b0}}};
      acc_hi = {{(32 - FRAC_BITS){cfg_r.hi[15]}}, cfg_r.hi, {FRAC_BITS{1'b0}}};
      p_s = err_neg_r ? -$signed({1'b0, p_r}) : $signed({1'b0, p_r});
      out_sum = {{15{p_s[24]}}, p_s} + {{8{acc_new[47]}}, acc_new[47:16]};
   end
   ppi_sat #(.IW(49), .OW(48)) u_acc_sat (
      .val (acc_sum),
      .lo  (acc_lo),
      .hi  (acc_hi),
      .res (acc_new)
   );
   ppi_sat #(.IW(40), .OW(16)) u_out_sat (
      .val (out_sum),
      .lo  (cfg_r.lo),
      .hi  (cfg_r.hi),
      .res (out_new)
   );
   // Stop clear overrides any pending update
   always_ff @(posedge clk) begin
      if (!rst_n || stop_clr) begin
         acc_r <= '0;
         out_r <= 16'sh0000;
      end else if (state_r == ST_APPLY) begin
         acc_r <= acc_new;
         out_r <= out_new;
      end
   end
   // Reference output only while the active place selects the controller
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pi_ref_active               <= 1'b0;
         controller_output_reference <= 16'sh0000;
      end else begin
         pi_ref_active               <= pi_sel;
         controller_output_reference <= pi_sel ? out_r : 16'sh0000;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         monitor <= '0;
      end else begin
         monitor.sp  <= sp;
         monitor.fb  <= fb;
         monitor.err <= err_mon;
         monitor.out <= out_r;
      end
   end
   // Reads answer on the next edge; unknown numbers read zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         par_rdata <= 16'h0000;
      end else if (par_rd) begin
         if (par_idx == IDX_PI_SETPOINT_MONITOR) begin
            par_rdata <= sp;
         end else if (par_idx == IDX_PI_FEEDBACK_MONITOR) begin
            par_rdata <= fb;
         end else if (par_idx == IDX_PI_ERROR_MONITOR) begin
            par_rdata <= err_mon;
         end else if (par_idx == IDX_PI_OUTPUT_MONITOR) begin
            par_rdata <= out_r;
         end else if (par_idx == IDX_SETPOINT_SOURCE_SELECT) begin
            par_rdata <= {13'h0, cfg_r.sp_src};
         end else if (par_idx == IDX_FEEDBACK_SOURCE_SELECT) begin
            par_rdata <= {15'h0, cfg_r.fb_src};
         end else if (par_idx == IDX_ERROR_NEGATION_ENABLE) begin
            par_rdata <= {15'h0, cfg_r.neg};
         end else if (par_idx == IDX_PROPORTIONAL_GAIN) begin
            par_rdata <= {4'h0, cfg_r.pgain};
         end else if (par_idx == IDX_INTEGRAL_TIME_SETTING) begin
            par_rdata <= {1'b0, cfg_r.ti};
         end else if (par_idx == IDX_OUTPUT_UPPER_LIMIT) begin
            par_rdata <= cfg_r.hi;
         end else if (par_idx == IDX_OUTPUT_LOWER_LIMIT) begin
            par_rdata <= cfg_r.lo;
         end else if (par_idx == IDX_STOP_RESET_BEHAVIOUR) begin
            par_rdata <= {15'h0, cfg_r.keep_run};
         end else begin
            par_rdata <= 16'h0000;
         end
      end
   end
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic signed [16:0] chk_err;
   assign chk_err = {monitor.sp[15], monitor.sp} - {monitor.fb[15], monitor.fb};

   ref_gate_a: assert property (pi_sel |=> pi_ref_active && controller_output_reference == $past(out_r))
      else $error("reference not passed while selected");
   ref_block_a: assert property (!pi_sel |=> !pi_ref_active && controller_output_reference == 16'sh0000)
      else $error("reference leaked while not selected");
   kbd_gate_a: assert property ($changed(keypad_setpoint_r) |-> $past(keypad_ok))
      else $error("keypad setpoint moved while not allowed");
   kbd_range_a: assert property (keypad_setpoint_r >= 16'sh0000 && keypad_setpoint_r <= KEYPAD_MAX)
      else $error("keypad setpoint out of range");
   sp_read_a: assert property (par_rd && par_idx == IDX_PI_SETPOINT_MONITOR |=> par_rdata == $past(sp))
      else $error("setpoint read wrong");
   fb_sel_a: assert property (cfg_r.fb_src |=> monitor.fb == $past(second_analog_reference))
      else $error("feedback monitor wrong source");
   err_mon_a: assert property (chk_err[16] == chk_err[15] |-> monitor.err == chk_err[15:0])
      else $error("error monitor is not setpoint minus feedback");
   out_read_a: assert property (par_rd && par_idx == IDX_PI_OUTPUT_MONITOR |=> par_rdata == $past(out_r))
      else $error("output read wrong");
   sp_serial_a: assert property (cfg_r.sp_src == SRC_SERIAL |=> monitor.sp == $past(serial_link_setpoint))
      else $error("serial setpoint not selected");
   neg_dir_a: assert property (state_r == ST_IDLE && tick && err_raw != 17'sh0
      |=> err_neg_r == ($past(err_raw[16]) ^ $past(cfg_r.neg))) else $error("error sign not negated as set");
   gain_rng_a: assert property (cfg_r.pgain >= PGAIN_MIN && cfg_r.pgain <= PGAIN_MAX
      && cfg_r.ti >= TI_MIN && cfg_r.ti <= TI_MAX) else $error("gain or time out of range");
   out_lim_a: assert property (state_r == ST_APPLY && !par_wr |=> out_r <= cfg_r.hi && out_r >= cfg_r.lo)
      else $error("output outside limits");
   stop_clr_a: assert property (stop_clr |=> out_r == 16'sh0000 && acc_r == 48'sh0)
      else $error("output not cleared at stop");
   windup_a: assert property (state_r == ST_APPLY && hold && !err_neg_r && !stop_clr
      |=> acc_r <= $past(acc_r)) else $error("integrator grew into upper limit");

   kbd_step_c: cover property (keypad_ok && keypad_up ##1 keypad_setpoint_r > 16'sh0000);
   apply_c:    cover property (state_r == ST_APPLY && pi_sel && drive_run);
   hold_c:     cover property (state_r == ST_APPLY && hold);
   stop_c:     cover property (drive_run ##1 stop_clr);
endmodule

//--- dv/ppi_ctrl_test.sv
// Self-checking bench for the process PI controller top.
// Assumes the design package is compiled first; drives on falling edges.
`timescale 1ns/1ps
module ppi_ctrl_test
   import ppi_pkg::*;
;
   localparam int SC = 200;
   logic              clk, rst_n, par_wr, par_rd, kup, kdn, run, pb, act;
   logic [9:0]        idx;
   logic [15:0]       wd, rdata;
   logic signed [15:0] a1, a2, ser, cor;
   logic [2:0]        ra, rb;
   ppi_mon_t          mon;
   int                fails, compares;
   ppi_ctrl #(.SAMPLE_CYC(SC)) u_dut (.clk(clk), .rst_n(rst_n), .par_wr(par_wr), .par_rd(par_rd),
      .par_idx(idx), .par_wdata(wd), .par_rdata(rdata), .first_analog_reference(a1),
      .second_analog_reference(a2), .serial_link_setpoint(ser), .keypad_up(kup), .keypad_down(kdn),
      .drive_run(run), .place_b(pb), .ref_src_a(ra), .ref_src_b(rb),
      .controller_output_reference(cor), .pi_ref_active(act), .monitor(mon));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic complete_run();
      if (fails == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] i, input logic [15:0] d);
      @(negedge clk) begin par_wr = 1'b1; idx = i; wd = d; end
      @(negedge clk) par_wr = 1'b0;
   endtask
   task automatic rd(input logic [9:0] i, input logic [15:0] exp);
      @(negedge clk) begin par_rd = 1'b1; idx = i; end
      @(negedge clk) par_rd = 1'b0;
      chk(rdata, exp);
   endtask
   task automatic press(input logic up);
      @(negedge clk) begin kup = up; kdn = ~up; end
      @(negedge clk) begin kup = 1'b0; kdn = 1'b0; end
   endtask
   // Two ticks plus the divider latency
   task automatic settle();
      repeat (2 * SC + 120) @(negedge clk);
   endtask
   task automatic t_reset();
      rd(IDX_PROPORTIONAL_GAIN, 16'h0064);
      rd(IDX_INTEGRAL_TIME_SETTING, 16'h0064);
      rd(IDX_OUTPUT_UPPER_LIMIT, 16'h03e8);
      rd(IDX_OUTPUT_LOWER_LIMIT, 16'h0000);
      rd(10'h3ff, 16'h0000);
      chk(mon.out, 16'h0000);
   endtask
   task automatic t_keypad();
      chk({15'h0000, act}, 16'h0001);
      press(1'b0);
      repeat (2) @(negedge clk);
      chk(mon.sp, 16'h0000);
      for (int n = 0; n < 1001; n++) press(1'b1);
      repeat (2) @(negedge clk);
      chk(mon.sp, 16'h03e8);
      ra = 3'h0;
      repeat (2) @(negedge clk);
      press(1'b0);
      repeat (2) @(negedge clk);
      chk(mon.sp, 16'h03e8);
      ra = 3'h4;
      press(1'b0);
      repeat (2) @(negedge clk);
      chk(mon.sp, 16'h03e7);
   endtask
   task automatic t_select();
      logic [15:0] exp [4];
      logic [15:0] code [4];
      exp = '{16'h0111, 16'h0022, 16'h0064, 16'h0000};
      code = '{16'h0001, 16'h0002, 16'h0004, 16'h0003};
      for (int n = 0; n < 4; n++) begin
         wr(IDX_SETPOINT_SOURCE_SELECT, code[n]);
         repeat (2) @(negedge clk);
         chk(mon.sp, exp[n]);
      end
      wr(IDX_SETPOINT_SOURCE_SELECT, 16'h0004);
      repeat (2) @(negedge clk);
      chk(mon.fb, 16'h0111);
      wr(IDX_FEEDBACK_SOURCE_SELECT, 16'h0001);
      repeat (2) @(negedge clk);
      chk(mon.fb, 16'h0022);
      chk(mon.err, 16'h0042);
      rd(IDX_PI_SETPOINT_MONITOR, 16'h0064);
      rd(IDX_PI_ERROR_MONITOR, 16'h0042);
   endtask
   task automatic t_ranges();
      wr(IDX_PROPORTIONAL_GAIN, 16'h1388);
      rd(IDX_PROPORTIONAL_GAIN, 16'h0bb8);
      wr(IDX_PROPORTIONAL_GAIN, 16'h0000);
      rd(IDX_PROPORTIONAL_GAIN, 16'h0001);
      wr(IDX_INTEGRAL_TIME_SETTING, 16'h0000);
      rd(IDX_INTEGRAL_TIME_SETTING, 16'h0001);
      wr(IDX_INTEGRAL_TIME_SETTING, 16'h9c40);
      rd(IDX_INTEGRAL_TIME_SETTING, 16'h7d00);
      wr(IDX_FEEDBACK_SOURCE_SELECT, 16'h0002);
      rd(IDX_FEEDBACK_SOURCE_SELECT, 16'h0001);
   endtask
   task automatic t_loop();
      run = 1'b1;
      wr(IDX_PROPORTIONAL_GAIN, 16'h0064);
      settle();
      chk(mon.out, 16'h0042);
      chk(cor, 16'h0042);
      wr(IDX_PROPORTIONAL_GAIN, 16'h012c);
      settle();
      chk(mon.out, 16'h00c6);
      pb = 1'b1;
      repeat (3) @(negedge clk);
      chk(cor, 16'h0000);
      chk({15'h0000, act}, 16'h0000);
      rb = 3'h4;
      repeat (3) @(negedge clk);
      chk(cor, 16'h00c6);
      pb = 1'b0;
      ser = 16'sh03e8;
      wr(IDX_OUTPUT_UPPER_LIMIT, 16'h00c8);
      settle();
      chk(mon.out, 16'h00c8);
      wr(IDX_OUTPUT_LOWER_LIMIT, 16'hff6a);
      wr(IDX_ERROR_NEGATION_ENABLE, 16'h0001);
      settle();
      chk(mon.out, 16'hff6a);
      chk(mon.err, 16'h03c6);
      run = 1'b0;
      repeat (3) @(negedge clk);
      chk(mon.out, 16'h0000);
      wr(IDX_STOP_RESET_BEHAVIOUR, 16'h0001);
      settle();
      chk(mon.out, 16'hff6a);
      rd(IDX_PI_OUTPUT_MONITOR, 16'hff6a);
   endtask
   initial begin
      rst_n = 1'b0; par_wr = 1'b0; par_rd = 1'b0; idx = 10'h000; wd = 16'h0000;
      kup = 1'b0; kdn = 1'b0; run = 1'b0; pb = 1'b0; ra = 3'h4; rb = 3'h0;
      a1 = 16'sh0111; a2 = 16'sh0022; ser = 16'sh0064;
      fails = 0; compares = 0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_reset();
      t_keypad();
      t_select();
      t_ranges();
      t_loop();
      complete_run();
   end
   // Run needs about 4700 cycles
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      complete_run();
   end
endmodule
